// ==== rtl/sys_support_pkg.sv ====
package sys_support_pkg;
    localparam int NUM_RANGES = 6;
    localparam int NUM_WAIT_REGS = 3;
    localparam int KEY_W = 30;
    localparam int KEY_LSB = 1;
    localparam int KEY_MSB = 30;
    localparam int ADR_LSB = 10;
    localparam int SPEC_W = 13;
    localparam int SPEC_HI_LSB = 19;
    localparam int SPEC_LO_LSB = 6;
    localparam int CNT_W = 5;
    localparam int FAR_LSB = 8;
    localparam int NEAR_LSB = 3;
    localparam int WAITEN_BIT = 2;
    localparam int SINGLE_BIT = 1;
    localparam int OVR_BIT = 0;
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hFFFF;

    // Byte offsets on the APB side
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE0 = 8'h04;
    localparam logic [7:0] OFS_MASK0 = 8'h1C;
    localparam logic [7:0] OFS_WAIT0 = 8'h34;
    localparam logic [7:0] OFS_PAGE_MASK = 8'h40;
    localparam logic [7:0] OFS_TIMER = 8'h44;
    localparam logic [7:0] OFS_PRELOAD = 8'h48;
    localparam logic [7:0] OFS_STATUS = 8'h4C;

    localparam int CTRL_CSEN_LSB = 0;
    localparam int CTRL_PAGE_EN_BIT = 8;
    localparam int CTRL_TIMER_ON_BIT = 9;
    localparam logic [31:0] CTRL_WMASK = 32'h0000033F;

    localparam logic [NUM_RANGES-1:0] CS_EN_RESET = 6'h01;
    localparam logic [7:0] RANGE0_ASI = 8'h09;
    localparam logic [31:0] BASE0_VALUE = 32'h04800000;
    localparam logic [31:0] KEY_FIELD_MASK = 32'h7FFFFFFE;
    localparam logic [31:0] MASK0_RESET = 32'h0000003E;
    localparam logic [31:0] WAIT0_RESET = 32'hFFE80000;
    localparam logic [31:0] WAIT_FIELD_MASK = 32'hFFFFFFC0;
endpackage : sys_support_pkg

// ==== rtl/tick_timer.sv ====
module tick_timer
    import sys_support_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic run, // Timer on
    input wire logic load, // Direct count load strobe
    input wire logic [TIMER_W-1:0] loadValue, // Value for direct load
    input wire logic [TIMER_W-1:0] preload, // Reload value
    output logic [TIMER_W-1:0] count, // Current count
    output logic tickOutN // Overflow pulse, low
);
    logic [TIMER_W-1:0] count_q;
    logic tick_q;
    logic overflow;

    assign overflow = run && (count_q == TIMER_MAX);
    assign count = count_q;
    assign tickOutN = ~tick_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= loadValue; // [RULE_21]
        end else if (overflow) begin
            count_q <= preload; // [RULE_20]
        end else if (run) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Pulse is one clock wide, usable as a refresh request
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_q <= 1'b0; // [RULE_22]
        end else begin
            tick_q <= overflow && !load; // [RULE_20]
        end
    end

    a_tick_reload: assert property (@(posedge clock) disable iff (sys_rst)
        overflow && !load |=> count_q == $past(preload) && !tickOutN) // [RULE_20]
        else $error("timer did not reload on overflow");
    a_timer_off: assert property (@(posedge clock) disable iff (sys_rst)
        !run |=> tickOutN && (count_q == $past(count_q) || $past(load))) // [RULE_21]
        else $error("stopped timer moved or ticked");
    c_tick: cover property (@(posedge clock) disable iff (sys_rst) !tickOutN);
endmodule : tick_timer

// ==== rtl/chip_select_wait_state_timer.sv ====
// Function
// [RULE_01] Six ranges drive active-low selects
// [RULE_02] Range zero base fixed, mask programmable
// [RULE_03] Reset enables select zero only
// [RULE_04] Compare only bits with mask zero
// [RULE_05] Selects high outside transactions
// [RULE_06] Range zero mask ignores ADR 14:10
// [RULE_07] Two 13-bit specifiers per wait register
// [RULE_08] Far page waits far count plus one
// [RULE_09] Same page waits near count plus one
// [RULE_10] Wait enable zero: no internal ready; the code still gives internal ready in the strobe cycle when single is set
// [RULE_11] Single cycle: ready in access cycle
// [RULE_12] Software never sets wait and single
// [RULE_13] Override stops counter on early ready
// [RULE_14] Range zero resets to 32 waits
// [RULE_15] Store previous key, flag page hit
// [RULE_16] Page compare where mask bit one
// [RULE_17] No hit after foreign bus master
// [RULE_18] Page detection disabled after reset
// [RULE_19] Refresh logic should request the bus
// [RULE_20] 16-bit timer reloads, pulses on overflow
// [RULE_21] Count write loads; off bit stops
// [RULE_22] Reset: timer off, tick output high
// [RULE_23] Count from strobe; readies combine
module chip_select_wait_state_timer
    import sys_support_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic addrStrobeN, // Transaction start strobe, low
    input wire logic [31:0] busAddr, // Driven byte address
    input wire logic [7:0] spaceIdentifier, // Driven space identifier
    input wire logic extReadyN, // External ready, low
    input wire logic busGrantN, // Bus handed to other master, low
    output logic [NUM_RANGES-1:0] rangeSelN, // Range selects, low
    output logic pageHitN, // Same page, low
    output logic intReadyN, // Internal ready, low
    output logic readyN, // Combined ready, low
    output logic tick_out_n // Timer overflow pulse, low
);
    typedef logic [SPEC_W-1:0] spec_t;

    logic [31:0] ctrl_q;
    logic [31:0] base_q [NUM_RANGES];
    logic [31:0] mask_q [NUM_RANGES];
    logic [31:0] wait_q [NUM_WAIT_REGS];
    logic [31:0] pageMask_q;
    logic [TIMER_W-1:0] preload_q;
    logic [TIMER_W-1:0] timerCount;
    logic [31:0] prdata_q;
    logic pslverr_d;

    logic [KEY_W-1:0] curKey;
    logic [KEY_W-1:0] pageKey_q;
    logic pageValid_q;
    logic foreign_q;
    logic pageHitNow;
    logic pageHit_q;
    logic start;
    logic txn_q;
    logic inTxn;
    logic [NUM_RANGES-1:0] rangeHit;
    logic anyHit;
    spec_t selSpec;
    logic selWaitEn;
    logic selSingle;
    logic [CNT_W-1:0] waitCnt_q;
    logic waitBusy_q;
    logic override_q;
    logic counterDone;
    logic intReady;
    logic extReady;
    logic busReady;
    logic wrEn;
    logic timerLoad;

    // Key layout matches the base and mask register bit positions
    function automatic logic [KEY_W-1:0] regKey(input logic [31:0] r);
        regKey = r[KEY_MSB:KEY_LSB];
    endfunction : regKey

    function automatic logic keyMatch(input logic [KEY_W-1:0] a,
                                      input logic [KEY_W-1:0] b,
                                      input logic [KEY_W-1:0] care);
        keyMatch = ((a ^ b) & care) == '0;
    endfunction : keyMatch

    function automatic spec_t rangeSpec(input logic [31:0] w, input int r);
        if (r % 2 == 0) begin
            rangeSpec = w[SPEC_HI_LSB +: SPEC_W]; // [RULE_07]
        end else begin
            rangeSpec = w[SPEC_LO_LSB +: SPEC_W]; // [RULE_07]
        end
    endfunction : rangeSpec

    function automatic logic isReg(input logic [7:0] a, input logic [7:0] b,
                                   input int n);
        isReg = (a >= b) && (a < b + 8'(4 * n)) && (a[1:0] == 2'b00);
    endfunction : isReg

    assign curKey = {spaceIdentifier, busAddr[31:ADR_LSB]};
    assign start = !addrStrobeN;
    assign extReady = !extReadyN;
    assign inTxn = start || txn_q;

    // Address range decode
    genvar g;
    generate
        for (g = 0; g < NUM_RANGES; g++) begin : gRange
            assign rangeHit[g] = ctrl_q[CTRL_CSEN_LSB + g] &&
                keyMatch(curKey, regKey(base_q[g]), ~regKey(mask_q[g]));
            // [RULE_01] [RULE_04]
            assign rangeSelN[g] = !(inTxn && rangeHit[g]); // [RULE_05]
        end
    endgenerate

    assign anyHit = |rangeHit;

    // Lowest numbered matching range supplies the wait specifier
    always_comb begin
        selSpec = '0;
        for (int r = NUM_RANGES - 1; r >= 0; r--) begin
            if (rangeHit[r]) begin
                selSpec = rangeSpec(wait_q[r / 2], r);
            end
        end
    end

    assign selWaitEn = anyHit && selSpec[WAITEN_BIT];
    assign selSingle = anyHit && selSpec[SINGLE_BIT];

    // Same-page detection
    assign pageHitNow = ctrl_q[CTRL_PAGE_EN_BIT] && pageValid_q && // [RULE_18]
        !foreign_q && // [RULE_17]
        keyMatch(curKey, pageKey_q, regKey(pageMask_q)); // [RULE_15] [RULE_16]

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pageKey_q <= '0;
            pageValid_q <= 1'b0;
        end else if (start) begin
            pageKey_q <= curKey; // [RULE_15]
            pageValid_q <= 1'b1;
        end
    end

    // Set by a foreign grant, cleared by our next own strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            foreign_q <= 1'b0;
        end else if (!busGrantN) begin
            foreign_q <= 1'b1; // [RULE_17]
        end else if (start) begin
            foreign_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pageHit_q <= 1'b0;
            txn_q <= 1'b0;
        end else if (start) begin
            pageHit_q <= pageHitNow;
            txn_q <= !busReady;
        end else if (busReady) begin
            pageHit_q <= 1'b0;
            txn_q <= 1'b0;
        end
    end

    assign pageHitN = !(start ? pageHitNow : (txn_q && pageHit_q));

    // Wait-state counter
    // A stale count must not end the next transaction in its strobe cycle
    assign counterDone = waitBusy_q && (waitCnt_q == '0) && !start;
    assign intReady = (start && selSingle) || counterDone; // [RULE_11]
    assign busReady = intReady || extReady; // [RULE_23]
    assign intReadyN = !intReady;
    assign readyN = !busReady; // [RULE_23]

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            waitBusy_q <= 1'b0;
            waitCnt_q <= '0;
            override_q <= 1'b0;
        end else if (start) begin
            waitBusy_q <= selWaitEn && !selSingle; // [RULE_10] [RULE_23]
            override_q <= selSpec[OVR_BIT];
            if (pageHitNow) begin
                waitCnt_q <= selSpec[NEAR_LSB +: CNT_W]; // [RULE_09]
            end else begin
                waitCnt_q <= selSpec[FAR_LSB +: CNT_W]; // [RULE_08]
            end
        end else if (waitBusy_q && override_q && extReady) begin
            waitBusy_q <= 1'b0; // [RULE_13]
        end else if (counterDone) begin
            waitBusy_q <= 1'b0;
        end else if (waitBusy_q) begin
            waitCnt_q <= waitCnt_q - 1'b1;
        end
    end

    // APB slave: no wait states, read data captured in the setup phase
    assign wrEn = psel && penable && pwrite;
    assign timerLoad = wrEn && (paddr == OFS_TIMER); // [RULE_21]
    assign pready = 1'b1;
    assign prdata = prdata_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= 32'(CS_EN_RESET); // [RULE_03] [RULE_18] [RULE_22]
        end else if (wrEn && paddr == OFS_CTRL) begin
            ctrl_q <= pwdata & CTRL_WMASK; // [RULE_21]
        end
    end

    generate
        for (g = 0; g < NUM_RANGES; g++) begin : gRegs
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    base_q[g] <= (g == 0) ? BASE0_VALUE : '0;
                end else if (g != 0 && wrEn &&
                             paddr == OFS_BASE0 + 8'(4 * g)) begin
                    base_q[g] <= pwdata & KEY_FIELD_MASK; // [RULE_02]
                end
            end
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    mask_q[g] <= (g == 0) ? MASK0_RESET : '0; // [RULE_06]
                end else if (wrEn && paddr == OFS_MASK0 + 8'(4 * g)) begin
                    mask_q[g] <= pwdata & KEY_FIELD_MASK;
                end
            end
        end
        for (g = 0; g < NUM_WAIT_REGS; g++) begin : gWait
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    wait_q[g] <= (g == 0) ? WAIT0_RESET : '0; // [RULE_14]
                end else if (wrEn && paddr == OFS_WAIT0 + 8'(4 * g)) begin
                    wait_q[g] <= pwdata & WAIT_FIELD_MASK; // [RULE_07]
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pageMask_q <= '0;
            preload_q <= '0;
        end else if (wrEn && paddr == OFS_PAGE_MASK) begin
            pageMask_q <= pwdata & KEY_FIELD_MASK;
        end else if (wrEn && paddr == OFS_PRELOAD) begin
            preload_q <= pwdata[TIMER_W-1:0];
        end
    end

    always_comb begin
        pslverr_d = 1'b0;
        if (!(paddr == OFS_CTRL || isReg(paddr, OFS_BASE0, NUM_RANGES) ||
              isReg(paddr, OFS_MASK0, NUM_RANGES) ||
              isReg(paddr, OFS_WAIT0, NUM_WAIT_REGS) ||
              paddr == OFS_PAGE_MASK || paddr == OFS_TIMER ||
              paddr == OFS_PRELOAD || paddr == OFS_STATUS)) begin
            pslverr_d = 1'b1;
        end
    end

    assign pslverr = psel && penable && pslverr_d;

    // Read data registered in setup so the access phase can finish at once
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prdata_q <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= '0;
            for (int r = 0; r < NUM_RANGES; r++) begin
                if (paddr == OFS_BASE0 + 8'(4 * r)) begin
                    prdata_q <= base_q[r];
                end
                if (paddr == OFS_MASK0 + 8'(4 * r)) begin
                    prdata_q <= mask_q[r];
                end
            end
            for (int w = 0; w < NUM_WAIT_REGS; w++) begin
                if (paddr == OFS_WAIT0 + 8'(4 * w)) begin
                    prdata_q <= wait_q[w];
                end
            end
            case (paddr)
                OFS_CTRL: prdata_q <= ctrl_q;
                OFS_PAGE_MASK: prdata_q <= pageMask_q;
                OFS_TIMER: prdata_q <= 32'(timerCount);
                OFS_PRELOAD: prdata_q <= 32'(preload_q);
                OFS_STATUS: prdata_q <= {22'h000000, waitBusy_q,
                    pageHit_q, txn_q, foreign_q, ~rangeSelN};
                default: ;
            endcase
        end
    end

    tick_timer uTimer (
        .clock(clock),
        .sys_rst(sys_rst),
        .run(ctrl_q[CTRL_TIMER_ON_BIT]),
        .load(timerLoad),
        .loadValue(pwdata[TIMER_W-1:0]),
        .preload(preload_q),
        .count(timerCount),
        .tickOutN(tick_out_n)
    );

    // Helper: cycles since the counter was loaded, and its load value
    logic [CNT_W:0] elapsed_q;
    logic [CNT_W-1:0] loaded_q;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            elapsed_q <= '0;
            loaded_q <= '0;
        end else if (start) begin
            elapsed_q <= '0;
            loaded_q <= pageHitNow ? selSpec[NEAR_LSB +: CNT_W] :
                selSpec[FAR_LSB +: CNT_W];
        end else if (waitBusy_q) begin
            elapsed_q <= elapsed_q + 1'b1;
        end
    end

    a_idle_sel_high: assert property (@(posedge clock) disable iff (sys_rst)
        !inTxn |-> &rangeSelN) // [RULE_05]
        else $error("range select active outside a transaction");
    a_sel_matches: assert property (@(posedge clock) disable iff (sys_rst)
        start |-> rangeSelN == ~rangeHit) // [RULE_01]
        else $error("range select does not follow decode");
    a_range0_base: assert property (@(posedge clock) disable iff (sys_rst)
        base_q[0] == BASE0_VALUE) // [RULE_02]
        else $error("range zero base changed");
    a_reset_values: assert property (@(posedge clock)
        $past(sys_rst) && !sys_rst |-> ctrl_q == 32'(CS_EN_RESET) &&
        mask_q[0] == MASK0_RESET && wait_q[0] == WAIT0_RESET) // [RULE_03]
        else $error("wrong reset configuration");
    a_single_ready: assert property (@(posedge clock) disable iff (sys_rst)
        start && selSingle |-> !intReadyN && !readyN) // [RULE_11]
        else $error("single-cycle range not ready at once");
    a_no_wait: assert property (@(posedge clock) disable iff (sys_rst)
        start && !selWaitEn && !selSingle |-> intReadyN ##1 !waitBusy_q)
        // [RULE_10]
        else $error("internal ready with wait disabled");
    a_wait_count: assert property (@(posedge clock) disable iff (sys_rst)
        counterDone |-> elapsed_q == {1'b0, loaded_q}) // [RULE_08]
        else $error("wait count off");
    a_wait_near: assert property (@(posedge clock) disable iff (sys_rst)
        start && selWaitEn && !selSingle && pageHitNow |=>
        waitCnt_q == $past(selSpec[NEAR_LSB +: CNT_W])) // [RULE_09]
        else $error("same-page access did not load near count");
    a_override_stop: assert property (@(posedge clock) disable iff (sys_rst)
        waitBusy_q && override_q && extReady && !start |=> !waitBusy_q)
        // [RULE_13]
        else $error("override did not stop counter");
    a_foreign_nohit: assert property (@(posedge clock) disable iff (sys_rst)
        start && foreign_q |-> pageHitN) // [RULE_17]
        else $error("page hit after foreign master");
    a_page_off: assert property (@(posedge clock) disable iff (sys_rst)
        !ctrl_q[CTRL_PAGE_EN_BIT] |-> pageHitN) // [RULE_18]
        else $error("page hit while detection disabled");

    c_single: cover property (@(posedge clock) disable iff (sys_rst)
        start && selSingle);
    c_counted: cover property (@(posedge clock) disable iff (sys_rst)
        counterDone);
    c_page_hit: cover property (@(posedge clock) disable iff (sys_rst)
        start && pageHitNow && selWaitEn);
    c_override: cover property (@(posedge clock) disable iff (sys_rst)
        waitBusy_q && override_q && extReady);
endmodule : chip_select_wait_state_timer

// ==== bench/ext_memory_model.sv ====
module ext_memory_model (
    input wire logic clock, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic addrStrobeN, // Transaction start, low
    input wire logic readyN, // Combined ready, low
    input wire logic [7:0] delay, // Cycles from strobe to ready
    output logic extReadyN // External ready, low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q;
    logic [7:0] left_q;

    // A slow device answers late, a fast one early; delay must be 1 or more
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            left_q <= 8'h00;
        end else if (!addrStrobeN) begin
            busy_q <= 1'b1;
            left_q <= delay - 8'h01;
        end else if (!readyN) begin
            busy_q <= 1'b0;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end

    // Ready line has a pull-up, so it reads high whenever the device is idle
    assign extReadyN = !(busy_q && left_q == 8'h00);
endmodule : ext_memory_model

// ==== bench/chip_select_wait_state_timer_tb_top.sv ====
module chip_select_wait_state_timer_tb_top
    import sys_support_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] space_identifier;
        logic [5:0] sel;
        logic hit;
        logic [7:0] waits;
    } row_t;
    logic clock, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, spaceIdentifier, extDelay;
    logic [31:0] pwdata, prdata, busAddr;
    logic addrStrobeN, extReadyN, busGrantN, pageHitN, intReadyN, readyN;
    logic [5:0] rangeSelN;
    logic tick_out_n;
    int fails = 0;
    int compares = 0;
    row_t rows [7];

    chip_select_wait_state_timer chip_select_wait_state_timer_inst (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .addrStrobeN(addrStrobeN),
        .busAddr(busAddr), .spaceIdentifier(spaceIdentifier),
        .extReadyN(extReadyN), .busGrantN(busGrantN),
        .rangeSelN(rangeSelN), .pageHitN(pageHitN), .intReadyN(intReadyN),
        .readyN(readyN), .tick_out_n(tick_out_n));

    ext_memory_model ext_memory_model_inst (
        .clock(clock), .sys_rst(sys_rst), .addrStrobeN(addrStrobeN),
        .readyN(readyN), .delay(extDelay), .extReadyN(extReadyN));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic results();
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        for (n = 0; pready !== 1'b1; n++) begin
            if (n == 50) begin
                fails++;
                results();
            end
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] want,
            input logic wantErr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h00000000, rd, err);
        check(rd, want);
        check(32'(err), 32'(wantErr));
    endtask : rdchk

    // Strobe one transaction and count cycles from strobe to combined ready
    task automatic txn(input logic [31:0] a, input logic [7:0] s,
            output int n, output logic [5:0] sel, output logic hit);
        @(posedge clock);
        addrStrobeN <= 1'b0;
        busAddr <= a;
        spaceIdentifier <= s;
        @(negedge clock);
        sel = rangeSelN;
        hit = pageHitN;
        for (n = 0; readyN !== 1'b0; n++) begin
            if (n == 100) begin
                fails++;
                results();
            end
            @(posedge clock);
            addrStrobeN <= 1'b1;
            @(negedge clock);
        end
        @(posedge clock);
        addrStrobeN <= 1'b1;
        @(negedge clock);
        check(32'(rangeSelN), 32'h3F);
    endtask : txn

    // Bench stands in for refresh logic taking the bus
    task automatic grant();
        @(posedge clock);
        busGrantN <= 1'b0;
        repeat (2) @(posedge clock);
        busGrantN <= 1'b1;
    endtask : grant

    task automatic waitTick(output int n);
        for (n = 0; tick_out_n !== 1'b0; n++) begin
            if (n == 100) begin
                fails++;
                results();
            end
            @(negedge clock);
        end
    endtask : waitTick

    initial begin
        int n;
        logic [5:0] sel;
        logic hit;
        logic [31:0] t1;
        logic err;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {busAddr, spaceIdentifier} = '0;
        addrStrobeN = 1'b1;
        busGrantN = 1'b1;
        extDelay = 8'h05;
        rows = '{'{32'h100, 8'h09, 6'h3E, 1'b1, 8'h04},
            '{32'h200, 8'h09, 6'h3E, 1'b0, 8'h02},
            '{32'h10000040, 8'h0A, 6'h3D, 1'b1, 8'h00},
            '{32'h10000080, 8'h0A, 6'h3D, 1'b0, 8'h00},
            '{32'h2000, 8'h08, 6'h3F, 1'b1, 8'h07},
            '{32'h2000, 8'h09, 6'h3E, 1'b1, 8'h04},
            '{32'h10007C00, 8'h0A, 6'h3D, 1'b1, 8'h00}};
        repeat (3) @(posedge clock);
        @(negedge clock);
        check(32'({tick_out_n, pageHitN, intReadyN, rangeSelN}), 32'h1FF);
        @(posedge clock);
        sys_rst <= 1'b0;
        rdchk(OFS_CTRL, 32'h00000001, 1'b0);
        rdchk(OFS_BASE0, 32'h04800000, 1'b0);
        rdchk(OFS_MASK0, 32'h0000003E, 1'b0);
        rdchk(OFS_WAIT0, 32'hFFE80000, 1'b0);
        rdchk(OFS_TIMER, 32'h00000000, 1'b0);
        // Early external ready must freeze the counter for good
        txn(32'h0, 8'h09, n, sel, hit);
        check(n, 5);
        n = 0;
        repeat (40) begin
            @(negedge clock);
            if (intReadyN === 1'b0)
                n++;
        end
        check(n, 0);
        extDelay <= 8'h28;
        txn(32'h7C00, 8'h09, n, sel, hit);
        check(n, 32);
        check(32'({sel, hit}), 32'h7D);
        txn(32'h8000, 8'h09, n, sel, hit);
        check(32'({sel, n[7:0]}), 32'h3F28);
        wr(OFS_BASE0, 32'hFFFFFFFF);
        rdchk(OFS_BASE0, 32'h04800000, 1'b0);
        rdchk(8'h50, 32'h00000000, 1'b1);
        rdchk(8'h02, 32'h00000000, 1'b1);
        // Wait enable and single cycle never both set in one specifier
        wr(OFS_WAIT0 + 8'h04, 32'hFFEFFF7F);
        rdchk(OFS_WAIT0 + 8'h04, 32'hFFEFFF40, 1'b0);
        wr(OFS_CTRL, 32'h00000103);
        wr(OFS_BASE0 + 8'h04, 32'h05080000);
        wr(OFS_MASK0 + 8'h04, 32'h0000003E);
        wr(OFS_WAIT0, 32'h18600080);
        wr(OFS_PAGE_MASK, 32'h7FFFFFF8);
        extDelay <= 8'h07;
        grant();
        for (int i = 0; i < 7; i++) begin
            txn(rows[i].addr, rows[i].space_identifier, n, sel, hit);
            check(32'(sel), 32'(rows[i].sel));
            check(32'(hit), 32'(rows[i].hit));
            check(n, 32'(rows[i].waits));
        end
        txn(32'h10007C80, 8'h0A, n, sel, hit);
        check(32'(hit), 32'h0);
        grant();
        txn(32'h10007C80, 8'h0A, n, sel, hit);
        check(32'(hit), 32'h1);
        wr(OFS_WAIT0, 32'h18600000);
        txn(32'h10000000, 8'h0A, n, sel, hit);
        check(32'({sel, n[7:0]}), 32'h3D07);
        wr(OFS_PRELOAD, 32'h0000FFF0);
        wr(OFS_TIMER, 32'h0000FFF0);
        wr(OFS_CTRL, 32'h00000303);
        waitTick(n);
        @(negedge clock);
        check(32'(tick_out_n), 32'h1);
        waitTick(n);
        check(n + 1, 32'h00010000 - 32'h0000FFF0);
        // Reload lands with the tick, then three counts before the off write
        wr(OFS_CTRL, 32'h00000103);
        rdchk(OFS_TIMER, 32'h0000FFF3, 1'b0);
        apb(1'b0, OFS_TIMER, 32'h0, t1, err);
        repeat (5) @(posedge clock);
        rdchk(OFS_TIMER, t1, 1'b0);
        wr(OFS_TIMER, 32'h00001234);
        rdchk(OFS_TIMER, 32'h00001234, 1'b0);
        // Reset in mid-run must restore the boot configuration
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check(32'({tick_out_n, pageHitN, intReadyN, rangeSelN}), 32'h1FF);
        @(posedge clock);
        sys_rst <= 1'b0;
        rdchk(OFS_CTRL, 32'h00000001, 1'b0);
        rdchk(OFS_WAIT0, 32'hFFE80000, 1'b0);
        results();
    end
endmodule : chip_select_wait_state_timer_tb_top
